// ===== src/hprw_pin_drv.sv
`timescale 1ns/1ps
`default_nettype none
module hprw_pin_drv
	import hprw_pkg::*;
(
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic pinIn,
	output var  logic pinOut,
	output var  logic pinOe,
	hprw_pin_if.pin   port
);

	logic syncA_q, syncB_q, idle_q, out_q, oe_q;
	logic idle_d, out_d, oe_d;

	// idle level learned only while the line floats; pulled-up lines read high
	always_comb begin
		idle_d = idle_q;
		if (!oe_q && !port.drive) begin
			idle_d = syncB_q;
		end
		oe_d  = port.drive;
		out_d = port.driveHigh;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			syncA_q <= 1'b1;
			syncB_q <= 1'b1;
			idle_q  <= 1'b1;
			out_q   <= 1'b0;
			oe_q    <= 1'b0;
		end else begin
			syncA_q <= pinIn;
			syncB_q <= syncA_q;
			idle_q  <= idle_d;
			out_q   <= out_d;
			oe_q    <= oe_d;
		end
	end

	assign port.idleLevel = idle_q;
	assign pinOut         = out_q;
	assign pinOe          = oe_q;

endmodule
`default_nettype wire

// ===== src/hprw_pin_if.sv
`timescale 1ns/1ps
`default_nettype none
interface hprw_pin_if;
	logic drive;
	logic driveHigh;
	logic idleLevel;
	modport ctrl (output drive, output driveHigh, input idleLevel);
	modport pin  (input drive, input driveHigh, output idleLevel);
endinterface
`default_nettype wire

// ===== src/hprw_pkg.sv
package hprw_pkg;

	// clock and the common 1/32 s tick
	localparam int unsigned CLK_PERIOD_NS  = 50;
	localparam int unsigned TICK_PERIOD_US = 31250;
	localparam int unsigned TICK_CYCLES    = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;

	// durations counted in 1/32 s ticks
	localparam logic [7:0] TICKS_PER_SEC   = 8'h20;
	localparam logic [7:0] HOLD_LONG_TICKS = 8'h80;
	localparam logic [7:0] HOLD_SHORT_TICKS = 8'h08;
	localparam logic [7:0] RESET_PULSE_TICKS = 8'h20;
	localparam logic [7:0] EXTEND_MAX_TICKS = 8'hA0;
	localparam logic [7:0] PULSE_HOLD_CODE = 8'hFF;

	// function mask bit positions
	localparam int unsigned BIT_AUTO_POL     = 0;
	localparam int unsigned BIT_RESET_INVERT = 1;
	localparam int unsigned BIT_POWER_INVERT = 2;
	localparam int unsigned BIT_DISP_FOLLOW  = 4;
	localparam int unsigned BIT_KEY_RESET    = 5;
	localparam int unsigned BIT_KEY_POWER_ON = 6;
	localparam int unsigned BIT_KEY_POWER_OFF = 7;

	// reset values
	localparam logic [7:0] MASK_RESET      = 8'h01;
	localparam logic [7:0] PULSE_LEN_RESET = 8'h20;
	localparam logic       SENSE_SRC_RESET = 1'b1;

	// command codes and reply flag
	localparam logic [7:0] CMD_SWITCH_CFG = 8'h1C;
	localparam logic [7:0] CMD_WATCHDOG   = 8'h1D;
	localparam logic [7:0] REPLY_FLAG     = 8'h40;

	// register byte offsets
	localparam logic [7:0] ADDR_SWITCH_CFG = 8'h00;
	localparam logic [7:0] ADDR_WATCHDOG   = 8'h04;
	localparam logic [7:0] ADDR_REPLY      = 8'h08;
	localparam logic [7:0] ADDR_STATE      = 8'h0C;
	localparam logic [7:0] ADDR_STATUS_BASE = 8'h40;
	localparam logic [7:0] STATUS_BYTES    = 8'h0F;
	localparam logic [3:0] STATUS_IDX_MASK  = 4'h7;
	localparam logic [3:0] STATUS_IDX_WDOG  = 4'h8;
	localparam logic [3:0] STATUS_IDX_SENSE = 4'hB;

	// switch configuration word fields
	localparam int unsigned SWCFG_LEN_LSB = 8;
	localparam int unsigned SWCFG_SRC_BIT = 16;
	localparam int unsigned SWCFG_CNT_LSB = 24;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_ARM    = 2'b01,
		ST_PULSE  = 2'b11,
		ST_REBOOT = 2'b10
	} hprw_state_t;

	typedef enum logic [2:0] {
		K_NONE    = 3'h0,
		K_KEY_RST = 3'h1,
		K_PWR_ON  = 3'h2,
		K_PWR_OFF = 3'h3,
		K_WDOG    = 3'h4
	} hprw_kind_t;

endpackage

// ===== src/hprw_supervisor.sv
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module hprw_supervisor
	import hprw_pkg::*;
#(
	parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output var  logic [31:0] readdata,
	output var  logic        waitrequest,
	input  wire logic        confirmKey,
	input  wire logic        cancelKey,
	input  wire logic        supplySense,
	input  wire logic        gpioSense,
	input  wire logic        hostResetIn,
	output var  logic        hostResetOut,
	output var  logic        hostResetOe,
	input  wire logic        hostPowerIn,
	output var  logic        hostPowerOut,
	output var  logic        hostPowerOe,
	output var  logic        displayBlank,
	output var  logic        backlightOff,
	output var  logic [1:0]  messageCode,
	output var  logic        rebootReq
);

	function automatic logic [7:0] statusByte(input logic [3:0] idx, input logic [7:0] mask,
		input logic [7:0] wdog, input logic src);
		statusByte = 8'h00;
		if (idx == STATUS_IDX_MASK) statusByte = mask;
		if (idx == STATUS_IDX_WDOG) statusByte = wdog;
		if (idx == STATUS_IDX_SENSE) statusByte = {7'h00, src};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and tick divider

	logic [3:0]  syncA_q, syncB_q;
	logic [19:0] div_q, div_d;
	logic        tick_q, tick_d;

	always_comb begin
		div_d  = div_q + 20'h00001;
		tick_d = 1'b0;
		if (div_q == 20'(TICK_CYCLES_P - 1)) begin
			div_d  = 20'h00000;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			syncA_q <= 4'h0;
			syncB_q <= 4'h0;
			div_q   <= 20'h00000;
			tick_q  <= 1'b0;
		end else begin
			syncA_q <= {gpioSense, supplySense, cancelKey, confirmKey};
			syncB_q <= syncA_q;
			div_q   <= div_d;
			tick_q  <= tick_d;
		end
	end

	logic confirmK, cancelK;
	assign confirmK = syncB_q[0];
	assign cancelK  = syncB_q[1];

	////////////////////////////////////////////////////////////////////////////////
	// configuration, watchdog, reply and bus

	logic [7:0]  mask_q, mask_d, len_q, len_d, wdSec_q, wdSec_d;
	logic [4:0]  wdSub_q, wdSub_d;
	logic        src_q, src_d, wdPend_q, wdPend_d;
	logic        repValid_q, repValid_d, wait_q, wait_d;
	logic [7:0]  repType_q, repType_d;
	logic [31:0] rdata_q, rdata_d;
	logic        sense_q, sense_d, blank_q, blank_d, reboot_q, reboot_d;
	logic [1:0]  msg_q, msg_d;
	logic        wdTaken, lock, senseNow, doWrite, doRead;
	logic [1:0]  byteCnt;
	hprw_state_t state_q, state_d;
	hprw_kind_t  kind_q, kind_d;
	logic [7:0]  cnt_q, cnt_d;
	logic        ext_q, ext_d;

	assign senseNow = src_q ? syncB_q[2] : syncB_q[3];
	assign doWrite  = write && !wait_q;
	assign doRead   = read && !wait_q;
	assign byteCnt  = writedata[SWCFG_CNT_LSB +: 2];
	assign lock = (state_q == ST_PULSE && kind_q == K_KEY_RST) || state_q == ST_REBOOT;

	always_comb begin
		mask_d     = mask_q;
		len_d      = len_q;
		src_d      = src_q;
		wdSec_d    = wdSec_q;
		wdSub_d    = wdSub_q;
		wdPend_d   = wdPend_q && !wdTaken;
		repValid_d = repValid_q;
		repType_d  = repType_q;
		rdata_d    = rdata_q;
		wait_d     = !((read || write) && wait_q);
		sense_d    = senseNow;
		if (doRead && address == ADDR_REPLY) begin
			repValid_d = 1'b0;
		end
		if (read && wait_q) begin
			rdata_d = 32'h00000000;
			if (address == ADDR_SWITCH_CFG) begin
				rdata_d = {15'h0000, src_q, len_q, mask_q};
			end else if (address == ADDR_WATCHDOG) begin
				rdata_d = {24'h000000, wdSec_q};
			end else if (address == ADDR_REPLY) begin
				rdata_d = {23'h000000, repValid_q, repType_q};
			end else if (address == ADDR_STATE) begin
				rdata_d = {26'h0000000, hostPowerOe, hostResetOe, lock, wdPend_q,
					state_q};
			end else if (address >= ADDR_STATUS_BASE &&
					address < ADDR_STATUS_BASE + (STATUS_BYTES << 2) &&
					address[1:0] == 2'b00) begin
				rdata_d = {24'h000000, statusByte(4'(address[5:2]), mask_q, wdSec_q,
					src_q)};
			end
		end
		if (tick_q && wdSec_q != 8'h00) begin
			wdSub_d = wdSub_q + 5'h01;
			if (wdSub_q == 5'(TICKS_PER_SEC - 8'h01)) begin
				wdSub_d = 5'h00;
				wdSec_d = wdSec_q - 8'h01;
				if (wdSec_q == 8'h01) begin
					wdPend_d = 1'b1;
				end
			end
		end
		if (senseNow && !sense_q) begin
			wdSec_d = 8'h00;
		end
		if (doWrite && byteenable[0] && !lock) begin
			if (address == ADDR_SWITCH_CFG && byteCnt != 2'b00) begin
				mask_d = writedata[7:0];
				if (byteCnt >= 2'b10) begin
					len_d = writedata[SWCFG_LEN_LSB +: 8];
				end
				if (byteCnt == 2'b11) begin
					src_d = writedata[SWCFG_SRC_BIT];
				end
				repValid_d = 1'b1;
				repType_d  = CMD_SWITCH_CFG | REPLY_FLAG;
			end else if (address == ADDR_WATCHDOG) begin
				wdSec_d    = writedata[7:0];
				wdSub_d    = 5'h00;
				repValid_d = 1'b1;
				repType_d  = CMD_WATCHDOG | REPLY_FLAG;
			end
		end
		if (state_q == ST_REBOOT) begin
			wdSec_d = 8'h00;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mask_q     <= MASK_RESET;
			len_q      <= PULSE_LEN_RESET;
			src_q      <= SENSE_SRC_RESET;
			wdSec_q    <= 8'h00;
			wdSub_q    <= 5'h00;
			wdPend_q   <= 1'b0;
			repValid_q <= 1'b0;
			repType_q  <= 8'h00;
			rdata_q    <= 32'h00000000;
			wait_q     <= 1'b1;
			sense_q    <= 1'b0;
		end else begin
			mask_q     <= mask_d;
			len_q      <= len_d;
			src_q      <= src_d;
			wdSec_q    <= wdSec_d;
			wdSub_q    <= wdSub_d;
			wdPend_q   <= wdPend_d;
			repValid_q <= repValid_d;
			repType_q  <= repType_d;
			rdata_q    <= rdata_d;
			wait_q     <= wait_d;
			sense_q    <= sense_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// key gestures and pulse sequencing

	logic keyHeld, endPulse, holdMode;

	always_comb begin
		state_d  = state_q;
		kind_d   = kind_q;
		cnt_d    = cnt_q;
		ext_d    = ext_q;
		wdTaken  = 1'b0;
		endPulse = 1'b0;
		keyHeld  = (kind_q == K_PWR_OFF) ? cancelK : confirmK;
		// 255 holds until the host changes state
		holdMode = (kind_q == K_PWR_ON || kind_q == K_PWR_OFF) && len_q == PULSE_HOLD_CODE;
		reboot_d = (senseNow && !sense_q) || state_q == ST_REBOOT;
		unique case (state_q)
			ST_IDLE: begin
				cnt_d = 8'h00;
				ext_d = 1'b0;
				if (wdPend_q) begin
					// start on a tick so the pulse spans whole ticks
					if (tick_q) begin
						wdTaken = 1'b1;
						state_d = ST_PULSE;
						kind_d  = K_WDOG;
						cnt_d   = RESET_PULSE_TICKS;
					end
				end else if (confirmK && senseNow && mask_q[BIT_KEY_RESET]) begin
					state_d = ST_ARM;
					kind_d  = K_KEY_RST;
				end else if (confirmK && !senseNow && mask_q[BIT_KEY_POWER_ON]) begin
					state_d = ST_ARM;
					kind_d  = K_PWR_ON;
				end else if (cancelK && senseNow && mask_q[BIT_KEY_POWER_OFF]) begin
					state_d = ST_ARM;
					kind_d  = K_PWR_OFF;
				end
			end
			ST_ARM: begin
				if (!keyHeld || senseNow == (kind_q == K_PWR_ON)) begin
					state_d = ST_IDLE;
					kind_d  = K_NONE;
				end else if (tick_q) begin
					cnt_d = cnt_q + 8'h01;
					if (cnt_d == ((kind_q == K_PWR_ON) ? HOLD_SHORT_TICKS : HOLD_LONG_TICKS))
					begin
						state_d = ST_PULSE;
						cnt_d   = (kind_q == K_KEY_RST) ? RESET_PULSE_TICKS : len_q;
					end
				end
			end
			ST_PULSE: begin
				if (holdMode) begin
					endPulse = (kind_q == K_PWR_ON) ? senseNow : !senseNow;
				end else if (ext_q && !cancelK) begin
					endPulse = 1'b1;
				end else if (tick_q) begin
					// the closing tick is the last one of the pulse
					if (cnt_q > 8'h01) begin
						cnt_d = cnt_q - 8'h01;
					end else if (kind_q == K_PWR_OFF && !ext_q && cancelK) begin
						ext_d = 1'b1;
						cnt_d = EXTEND_MAX_TICKS;
					end else begin
						endPulse = 1'b1;
					end
				end
				if (endPulse) begin
					state_d = (kind_q == K_KEY_RST || kind_q == K_PWR_ON) ? ST_REBOOT : ST_IDLE;
					kind_d  = K_NONE;
				end
			end
			ST_REBOOT: begin
				state_d = ST_IDLE;
			end
		endcase
		blank_d = mask_q[BIT_DISP_FOLLOW] && !senseNow;
		msg_d   = 2'b00;
		if (state_q == ST_PULSE && kind_q == K_KEY_RST) msg_d = 2'b01;
		if (state_q == ST_PULSE && kind_q == K_PWR_ON) msg_d = 2'b10;
		if (state_q == ST_PULSE && kind_q == K_PWR_OFF) msg_d = 2'b11;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q  <= ST_IDLE;
			kind_q   <= K_NONE;
			cnt_q    <= 8'h00;
			ext_q    <= 1'b0;
			blank_q  <= 1'b0;
			msg_q    <= 2'b00;
			reboot_q <= 1'b0;
		end else begin
			state_q  <= state_d;
			kind_q   <= kind_d;
			cnt_q    <= cnt_d;
			ext_q    <= ext_d;
			blank_q  <= blank_d;
			msg_q    <= msg_d;
			reboot_q <= reboot_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// line drivers

	hprw_pin_if pinIf[2] ();
	logic [1:0] pinIn, pinOutW, pinOeW, invertBit, driveW;

	assign pinIn     = {hostPowerIn, hostResetIn};
	assign invertBit = {mask_q[BIT_POWER_INVERT], mask_q[BIT_RESET_INVERT]};
	assign driveW[0] = state_q == ST_PULSE && (kind_q == K_KEY_RST || kind_q == K_WDOG);
	assign driveW[1] = state_q == ST_PULSE && (kind_q == K_PWR_ON || kind_q == K_PWR_OFF);

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gLine
			assign pinIf[g].drive = driveW[g];
			assign pinIf[g].driveHigh = mask_q[BIT_AUTO_POL] ? !pinIf[g].idleLevel
				: invertBit[g];
			hprw_pin_drv uDrv (
				.clk     (clk),
				.reset_n (reset_n),
				.pinIn   (pinIn[g]),
				.pinOut  (pinOutW[g]),
				.pinOe   (pinOeW[g]),
				.port    (pinIf[g])
			);
		end
	endgenerate

	assign hostResetOut = pinOutW[0];
	assign hostResetOe  = pinOeW[0];
	assign hostPowerOut = pinOutW[1];
	assign hostPowerOe  = pinOeW[1];
	assign readdata     = rdata_q;
	assign waitrequest  = wait_q;
	assign displayBlank = blank_q;
	assign backlightOff = blank_q;
	assign messageCode  = msg_q;
	assign rebootReq    = reboot_q;

endmodule
`default_nettype wire

// ===== testbench/hprw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module hprw_host_model (
	input  wire logic resetOut,
	input  wire logic resetOe,
	input  wire logic powerOut,
	input  wire logic powerOe,
	output var  logic resetLevel,
	output var  logic powerLevel
);
	assign resetLevel = resetOe ? resetOut : 1'b1;
	assign powerLevel = powerOe ? powerOut : 1'b1;
endmodule
`default_nettype wire

// ===== testbench/hprw_supervisor_props.sv
`timescale 1ns/1ps
`default_nettype none
module hprw_supervisor_props (
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic       read,
	input wire logic       write,
	input wire logic       waitrequest,
	input wire logic       hostResetOut,
	input wire logic       hostResetOe,
	input wire logic       hostPowerOut,
	input wire logic       hostPowerOe,
	input wire logic       displayBlank,
	input wire logic       backlightOff,
	input wire logic [1:0] messageCode,
	input wire logic       rebootReq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic [9:0] rstOnCnt_q;
	logic [9:0] rstOnCnt_d;
	always_comb begin
		rstOnCnt_d = hostResetOe ? rstOnCnt_q + 10'h001 : 10'h000;
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			rstOnCnt_q <= 10'h000;
		else
			rstOnCnt_q <= rstOnCnt_d;
	end
	////////////////////////////////////////////////////////////////////////
	AST_RD_ANSWER: assert property ($rose(read) |-> ##1 !waitrequest)
		else $error("read not answered after one wait state");
	AST_WAIT_ONE: assert property (!waitrequest |-> $past(read || write) ##1 waitrequest)
		else $error("waitrequest low without request or too long");
	AST_RST_LEN: assert property ($fell(hostResetOe) |-> rstOnCnt_q inside {[256:272]})
		else $error("reset pulse length wrong");
	AST_RST_STEADY: assert property (hostResetOe && $past(hostResetOe) |-> $stable(hostResetOut))
		else $error("reset level changed inside pulse");
	AST_PWR_STEADY: assert property (hostPowerOe && $past(hostPowerOe) |-> $stable(hostPowerOut))
		else $error("power level changed inside pulse");
	AST_BLANK_PAIR: assert property (displayBlank == backlightOff)
		else $error("blank and backlight disagree");
	AST_MSG_PWR: assert property ($rose(messageCode == 2'h2) |-> ##[0:1] hostPowerOe)
		else $error("power on message without pulse");
	AST_MSG_RST: assert property ($rose(messageCode == 2'h1) |-> ##[0:1] hostResetOe)
		else $error("reset message without pulse");
	AST_ONE_LINE: assert property (!(hostResetOe && hostPowerOe))
		else $error("both lines driven");
	AST_REBOOT_ONE: assert property (rebootReq |=> !rebootReq)
		else $error("reboot request longer than one cycle");
	COV_RST: cover property ($rose(hostResetOe));
	COV_PWR: cover property ($rose(hostPowerOe));
	COV_REBOOT: cover property (rebootReq);
endmodule
bind hprw_supervisor hprw_supervisor_props u_props (
	.clk(clk),
	.reset_n(reset_n),
	.read(read),
	.write(write),
	.waitrequest(waitrequest),
	.hostResetOut(hostResetOut),
	.hostResetOe(hostResetOe),
	.hostPowerOut(hostPowerOut),
	.hostPowerOe(hostPowerOe),
	.displayBlank(displayBlank),
	.backlightOff(backlightOff),
	.messageCode(messageCode),
	.rebootReq(rebootReq)
);
`default_nettype wire

// ===== testbench/hprw_supervisor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module hprw_supervisor_tb;
	import hprw_pkg::*;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  address = 8'h00;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        confirmKey = 1'b0;
	logic        cancelKey = 1'b0;
	logic        supplySense = 1'b0;
	logic        gpioSense = 1'b0;
	logic        rstLvl;
	logic        pwrLvl;
	logic        hostResetOut, hostResetOe, hostPowerOut, hostPowerOe;
	logic        displayBlank, backlightOff, rebootReq;
	logic [1:0]  messageCode;
	logic [31:0] q;
	logic        lvl;
	logic [1:0]  msg;
	int          len;
	int          errCount = 0;
	int          nChecks = 0;
	always #25 clk = ~clk;
	hprw_supervisor #(.TICK_CYCLES_P(8)) DUT (.clk(clk), .reset_n(reset_n), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(4'hF),
		.readdata(readdata), .waitrequest(waitrequest), .confirmKey(confirmKey),
		.cancelKey(cancelKey), .supplySense(supplySense), .gpioSense(gpioSense),
		.hostResetIn(rstLvl), .hostResetOut(hostResetOut), .hostResetOe(hostResetOe),
		.hostPowerIn(pwrLvl), .hostPowerOut(hostPowerOut), .hostPowerOe(hostPowerOe),
		.displayBlank(displayBlank), .backlightOff(backlightOff),
		.messageCode(messageCode), .rebootReq(rebootReq));
	hprw_host_model u_host (.resetOut(hostResetOut), .resetOe(hostResetOe),
		.powerOut(hostPowerOut), .powerOe(hostPowerOe), .resetLevel(rstLvl), .powerLevel(pwrLvl));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		nChecks++;
		if (s !== e) begin
			errCount++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		address <= a;
		writedata <= d;
		write <= w;
		read <= !w;
		@(posedge clk);
		// only the watchdog ends an unanswered request
		while (waitrequest !== 1'b0)
			@(posedge clk);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		chk(q, e);
	endtask
	task automatic pulse(input logic p);
		int n;
		n = 0;
		// the edge that first sees the line driven counts too
		len = 1;
		while ((p ? hostPowerOe : hostResetOe) !== 1'b1 && n < 3000) begin
			n++;
			@(posedge clk);
		end
		if (n == 3000)
			errCount++;
		lvl = p ? hostPowerOut : hostResetOut;
		@(posedge clk);
		msg = messageCode;
		while ((p ? hostPowerOe : hostResetOe) === 1'b1 && len < 3000) begin
			len++;
			@(posedge clk);
		end
	endtask
	task automatic waitReboot(input int lim);
		int n;
		n = 0;
		while (rebootReq !== 1'b1 && n < lim) begin
			n++;
			@(posedge clk);
		end
		chk({31'h0, n < lim}, 32'h1);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", nChecks, errCount);
		if (errCount == 0 && nChecks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		#1000000;
		errCount++;
		test_done();
	end
	initial begin
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		rd(ADDR_SWITCH_CFG, 32'h0001_2001);
		rd(8'h5C, 32'h1);
		rd(8'h6C, 32'h1);
		rd(8'h30, 32'h0);
		bus(ADDR_SWITCH_CFG, 1'b1, 32'h0300_04F1);
		rd(ADDR_SWITCH_CFG, 32'h0000_04F1);
		rd(ADDR_REPLY, 32'h0000_015C);
		$display("test config done");
		// supply high but gpio selected and low: host counts as off
		supplySense <= 1'b1;
		repeat (8) @(posedge clk);
		chk(displayBlank, 32'h1);
		confirmKey <= 1'b1;
		fork
			pulse(1'b1);
			waitReboot(3000);
		join
		confirmKey <= 1'b0;
		chk(lvl, 32'h0);
		chk(msg, 32'h2);
		chk(len inside {[32:48]}, 32'h1);
		gpioSense <= 1'b1;
		waitReboot(20);
		repeat (4) @(posedge clk);
		chk(displayBlank, 32'h0);
		$display("test power on done");
		confirmKey <= 1'b1;
		fork
			pulse(1'b0);
			waitReboot(3000);
			begin
				repeat (1100) @(posedge clk);
				bus(ADDR_SWITCH_CFG, 1'b1, 32'h0100_0000);
			end
		join
		confirmKey <= 1'b0;
		chk(len inside {[256:272]}, 32'h1);
		chk(msg, 32'h1);
		rd(ADDR_SWITCH_CFG, 32'h0000_04F1);
		bus(ADDR_REPLY, 1'b0, 32'h0);
		chk(q[8], 32'h0);
		$display("test keypad reset done");
		cancelKey <= 1'b1;
		pulse(1'b1);
		cancelKey <= 1'b0;
		chk(msg, 32'h3);
		chk(len inside {[1312:1320]}, 32'h1);
		$display("test power off done");
		bus(ADDR_SWITCH_CFG, 1'b1, 32'h0100_0002);
		bus(ADDR_WATCHDOG, 1'b1, 32'h2);
		bus(ADDR_WATCHDOG, 1'b1, 32'h0);
		repeat (700) @(posedge clk);
		chk(hostResetOe, 32'h0);
		bus(ADDR_WATCHDOG, 1'b1, 32'h1);
		rd(ADDR_REPLY, 32'h0000_015D);
		pulse(1'b0);
		chk(lvl, 32'h1);
		chk(len inside {[256:272]}, 32'h1);
		repeat (600) @(posedge clk);
		chk(hostResetOe, 32'h0);
		$display("test watchdog done");
		// sense from the supply; length code holds the line until sense drops
		bus(ADDR_SWITCH_CFG, 1'b1, 32'h0301_FF90);
		repeat (4) @(posedge clk);
		chk(displayBlank, 32'h0);
		cancelKey <= 1'b1;
		fork
			pulse(1'b1);
			begin
				repeat (1400) @(posedge clk);
				supplySense <= 1'b0;
			end
		join
		cancelKey <= 1'b0;
		chk(lvl, 32'h0);
		chk(len inside {[368:392]}, 32'h1);
		chk(displayBlank, 32'h1);
		$display("test hold done");
		test_done();
	end
endmodule
`default_nettype wire
